// ### verilog/tmr8_cfg.svh
`ifndef TMR8_CFG_SVH
`define TMR8_CFG_SVH

// register word addresses
`define TMR8_ADDR_CTRL 4'h0
`define TMR8_ADDR_COUNT 4'h1
`define TMR8_ADDR_CMP_A 4'h2
`define TMR8_ADDR_CMP_B 4'h3
`define TMR8_ADDR_FLAGS 4'h4
`define TMR8_ADDR_FORCE 4'h5

// control register fields
`define TMR8_CTRL_WGM_LSB 0
`define TMR8_CTRL_CS_LSB 4
`define TMR8_CTRL_COMA_LSB 8
`define TMR8_CTRL_COMB_LSB 10
`define TMR8_CTRL_RESET 32'h0000_0000

// flag register fields
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_MA 1
`define TMR8_FLAG_MB 2

// force register fields
`define TMR8_FORCE_A 0
`define TMR8_FORCE_B 1

// counter values
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hFF

// prescale taps
`define TMR8_DIV_8 10'h007
`define TMR8_DIV_32 10'h01F
`define TMR8_DIV_64 10'h03F
`define TMR8_DIV_128 10'h07F
`define TMR8_DIV_256 10'h0FF
`define TMR8_DIV_1024 10'h3FF

`endif

// ### verilog/tmr8_pkg.sv
package tmr8_pkg;
    typedef enum logic [2:0] {
        TMR8_WGM_NORMAL = 3'h0,
        TMR8_WGM_PC_MAX = 3'h1,
        TMR8_WGM_CTC = 3'h2,
        TMR8_WGM_FAST_MAX = 3'h3,
        TMR8_WGM_RSV4 = 3'h4,
        TMR8_WGM_PC_CMP = 3'h5,
        TMR8_WGM_RSV6 = 3'h6,
        TMR8_WGM_FAST_CMP = 3'h7
    } tmr8_wgm_t;
    typedef enum logic [1:0] {
        TMR8_COM_NONE = 2'h0,
        TMR8_COM_TOGGLE = 2'h1,
        TMR8_COM_CLEAR = 2'h2,
        TMR8_COM_SET = 2'h3
    } tmr8_com_t;
endpackage : tmr8_pkg

// ### verilog/tmr8_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_cfg.svh"
module tmr8_prescale
    import tmr8_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // select and enable
    input wire logic [2:0] clock_source_sel,
    output logic tick
);
    logic [9:0] div_reg;
    logic [9:0] div_next;
    logic [9:0] tap;

    // free-running divider; restarting it on select change is not done
    assign div_next = div_reg + 10'h001;
    assign tap = (clock_source_sel == 3'h2) ? `TMR8_DIV_8 :
                 (clock_source_sel == 3'h3) ? `TMR8_DIV_32 :
                 (clock_source_sel == 3'h4) ? `TMR8_DIV_64 :
                 (clock_source_sel == 3'h5) ? `TMR8_DIV_128 :
                 (clock_source_sel == 3'h6) ? `TMR8_DIV_256 : `TMR8_DIV_1024;
    // one-cycle enable, never a derived clock
    assign tick = (clock_source_sel == 3'h0) ? 1'b0 :
                  (clock_source_sel == 3'h1) ? 1'b1 :
                  ((div_reg & tap) == tap);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= 10'h000;
        end
        else
        begin
            div_reg <= div_next;
        end
    end
endmodule : tmr8_prescale
`default_nettype wire

// ### verilog/tmr8_wave.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_cfg.svh"
module tmr8_wave
    import tmr8_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events and settings
    input wire logic match,
    input wire logic force_pulse,
    input wire logic pwm_mode,
    input wire logic [1:0] out_action,
    // port pin
    input wire logic port_value,
    input wire logic pin_dir_out,
    output logic wave_out,
    output logic pin_out,
    output logic pin_oe
);
    logic wave_reg;
    logic wave_next;
    logic act;
    logic nonpwm_force;

    assign nonpwm_force = force_pulse && !pwm_mode;
    assign act = (match && !pwm_mode) || nonpwm_force;
    // action read live from the control bits, not buffered
    always_comb
    begin
        wave_next = wave_reg;
        if (act)
        begin
            case (tmr8_com_t'(out_action))
                TMR8_COM_NONE: wave_next = wave_reg;
                TMR8_COM_TOGGLE: wave_next = !wave_reg;
                TMR8_COM_CLEAR: wave_next = 1'b0;
                TMR8_COM_SET: wave_next = 1'b1;
                default: wave_next = wave_reg;
            endcase
        end
    end

    // not reset by mode changes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wave_reg <= 1'b0;
        end
        else
        begin
            wave_reg <= wave_next;
        end
    end

    assign wave_out = wave_reg;
    // override is mode independent; direction stays with the port
    assign pin_out = (out_action != 2'h0) ? wave_reg : port_value;
    assign pin_oe = pin_dir_out;
endmodule : tmr8_wave
`default_nettype wire

// ### verilog/tmr8_top.sv
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_cfg.svh"
// Overview of operation
// - counter write blocks next tick's matches
// - writing count equal compare loses match
// - wave state survives mode changes
// - new action used at next match
// - nonzero action overrides port value
// - pin direction from port; mode independent
// - action zero leaves wave state alone
// - force applies action now, non-pwm
// - only mode selects counting sequence
// - action sets, clears or toggles
// - normal mode counts up, wraps
// - overflow flag set when count wraps, non-pwm
// - overflow flag cleared on interrupt ack
// - normal mode counter writes anytime
// - ctc clears counter at compare a
// - ctc compare a unbuffered, may wrap
// - ctc sets match flag a at top
// - ctc toggle gives half rate
// - prescale 1 to 1024 selectable
// - ctc overflow set at max to zero, not when compare a clears from max
// - match flag next tick; clear by ack/one
// - force sets no flag, keeps counter
// - processor write beats count or clear
// - select zero stops counter
module tmr8_top
    import tmr8_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt acknowledge from the processor
    input wire logic ovf_int_ack,
    input wire logic match_a_int_ack,
    input wire logic match_b_int_ack,
    // flag levels for the interrupt controller
    output logic overflow_flag,
    output logic match_flag_a,
    output logic match_flag_b,
    // port pins
    input wire logic port_value_a,
    input wire logic port_value_b,
    input wire logic pin_dir_out_a,
    input wire logic pin_dir_out_b,
    output logic pin_out_a,
    output logic pin_out_b,
    output logic pin_oe_a,
    output logic pin_oe_b,
    output logic wave_out_a,
    output logic wave_out_b
);
    logic [31:0] ctrl_reg;
    logic [7:0] counter_reg;
    logic [7:0] counter_next;
    logic [7:0] cmp_a_reg;
    logic [7:0] cmp_b_reg;
    logic ovf_reg;
    logic ma_reg;
    logic mb_reg;
    logic block_reg;
    logic block_next;
    logic pend_a_reg;
    logic pend_b_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic tick;
    logic [2:0] wave_gen_sel;
    logic [2:0] clock_source_sel;
    logic [1:0] out_action_a;
    logic [1:0] out_action_b;
    logic pwm_mode;
    logic ctc_mode;
    logic req;
    logic wr_go;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_flags;
    logic wr_force;
    logic raw_a;
    logic raw_b;
    logic hit_a;
    logic hit_b;
    logic wraps;
    logic ctc_clear;
    logic force_a;
    logic force_b;
    logic clr_ovf;
    logic clr_ma;
    logic clr_mb;
    logic [31:0] rdata_next;
    logic ack_next;
    logic set_ovf;
    logic set_ma;
    logic set_mb;
    logic ovf_next;
    logic ma_next;
    logic mb_next;

    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] r);
        addr_is = (a == r);
    endfunction : addr_is

    // control fields
    assign wave_gen_sel = ctrl_reg[`TMR8_CTRL_WGM_LSB +: 3];
    assign clock_source_sel = ctrl_reg[`TMR8_CTRL_CS_LSB +: 3];
    assign out_action_a = ctrl_reg[`TMR8_CTRL_COMA_LSB +: 2];
    assign out_action_b = ctrl_reg[`TMR8_CTRL_COMB_LSB +: 2];
    assign ctc_mode = (tmr8_wgm_t'(wave_gen_sel) == TMR8_WGM_CTC);
    // modes 0 and 2 are the non-pwm modes; pwm counting is out of scope here
    assign pwm_mode = (tmr8_wgm_t'(wave_gen_sel) != TMR8_WGM_NORMAL) && !ctc_mode;

    // bus: one wait cycle, then the access completes
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_reg;
    assign ack_next = req && !ack_reg;
    assign wr_go = avs_write && ack_reg;
    assign wr_ctrl = wr_go && addr_is(avs_address, `TMR8_ADDR_CTRL);
    assign wr_count = wr_go && addr_is(avs_address, `TMR8_ADDR_COUNT);
    assign wr_cmp_a = wr_go && addr_is(avs_address, `TMR8_ADDR_CMP_A);
    assign wr_cmp_b = wr_go && addr_is(avs_address, `TMR8_ADDR_CMP_B);
    assign wr_flags = wr_go && addr_is(avs_address, `TMR8_ADDR_FLAGS);
    assign wr_force = wr_go && addr_is(avs_address, `TMR8_ADDR_FORCE);
    assign avs_readdata = rdata_reg;

    // unmapped addresses read as zero
    assign rdata_next =
        addr_is(avs_address, `TMR8_ADDR_CTRL) ? ctrl_reg :
        addr_is(avs_address, `TMR8_ADDR_COUNT) ? {24'h000000, counter_reg} :
        addr_is(avs_address, `TMR8_ADDR_CMP_A) ? {24'h000000, cmp_a_reg} :
        addr_is(avs_address, `TMR8_ADDR_CMP_B) ? {24'h000000, cmp_b_reg} :
        addr_is(avs_address, `TMR8_ADDR_FLAGS) ? {29'h00000000, mb_reg, ma_reg, ovf_reg} :
        32'h00000000;

    // comparator; a counter write blocks matches until the next tick passes
    assign raw_a = (counter_reg == cmp_a_reg);
    assign raw_b = (counter_reg == cmp_b_reg);
    assign hit_a = tick && raw_a && !block_reg && !wr_count;
    assign hit_b = tick && raw_b && !block_reg && !wr_count;
    // block survives a stopped timer and ends with the next tick
    assign block_next = wr_count ? 1'b1 : (tick ? 1'b0 : block_reg);

    // counting depends on mode only, never on out_action
    assign ctc_clear = ctc_mode && raw_a && tick;
    assign wraps = tick && !wr_count && !ctc_clear && (counter_reg == `TMR8_MAX);
    always_comb
    begin
        counter_next = counter_reg;
        if (wr_count)
        begin
            counter_next = avs_writedata[7:0];
        end
        else if (ctc_clear)
        begin
            counter_next = `TMR8_BOTTOM;
        end
        else if (tick)
        begin
            counter_next = counter_reg + 8'h01;
        end
    end

    // force strobes are pulses, never stored; they set no flag
    assign force_a = wr_force && avs_writedata[`TMR8_FORCE_A];
    assign force_b = wr_force && avs_writedata[`TMR8_FORCE_B];
    assign clr_ovf = ovf_int_ack || (wr_flags && avs_writedata[`TMR8_FLAG_OVF]);
    assign clr_ma = match_a_int_ack || (wr_flags && avs_writedata[`TMR8_FLAG_MA]);
    assign clr_mb = match_b_int_ack || (wr_flags && avs_writedata[`TMR8_FLAG_MB]);

    // set wins over a same-cycle clear, so no event is lost
    assign set_ma = tick && pend_a_reg;
    assign set_mb = tick && pend_b_reg;
    assign set_ovf = wraps && !pwm_mode;
    assign ma_next = set_ma || (ma_reg && !clr_ma);
    assign mb_next = set_mb || (mb_reg && !clr_mb);
    assign ovf_next = set_ovf || (ovf_reg && !clr_ovf);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= ack_next;
        end
    end

    // read data registered from the address, so it stands at the completing edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= `TMR8_CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_reg <= {20'h00000, avs_writedata[11:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_a_reg <= 8'h00;
            cmp_b_reg <= 8'h00;
        end
        else
        begin
            if (wr_cmp_a)
            begin
                cmp_a_reg <= avs_writedata[7:0];
            end
            if (wr_cmp_b)
            begin
                cmp_b_reg <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            counter_reg <= 8'h00;
        end
        else
        begin
            counter_reg <= counter_next;
        end
    end

    // block flag kept apart: it must outlive a stopped timer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            block_reg <= 1'b0;
        end
        else
        begin
            block_reg <= block_next;
        end
    end

    // match seen at a tick, flag raised at the following tick; set beats clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_a_reg <= 1'b0;
            pend_b_reg <= 1'b0;
        end
        else if (tick)
        begin
            pend_a_reg <= hit_a;
            pend_b_reg <= hit_b;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ma_reg <= 1'b0;
            mb_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end
        else
        begin
            ma_reg <= ma_next;
            mb_reg <= mb_next;
            ovf_reg <= ovf_next;
        end
    end

    assign overflow_flag = ovf_reg;
    assign match_flag_a = ma_reg;
    assign match_flag_b = mb_reg;

    tmr8_prescale u_prescale
    (
        .clk(clk),
        .rst_n(rst_n),
        .clock_source_sel(clock_source_sel),
        .tick(tick)
    );

    tmr8_wave u_wave_a
    (
        .clk(clk),
        .rst_n(rst_n),
        .match(hit_a),
        .force_pulse(force_a),
        .pwm_mode(pwm_mode),
        .out_action(out_action_a),
        .port_value(port_value_a),
        .pin_dir_out(pin_dir_out_a),
        .wave_out(wave_out_a),
        .pin_out(pin_out_a),
        .pin_oe(pin_oe_a)
    );

    tmr8_wave u_wave_b
    (
        .clk(clk),
        .rst_n(rst_n),
        .match(hit_b),
        .force_pulse(force_b),
        .pwm_mode(pwm_mode),
        .out_action(out_action_b),
        .port_value(port_value_b),
        .pin_dir_out(pin_dir_out_b),
        .wave_out(wave_out_b),
        .pin_out(pin_out_b),
        .pin_oe(pin_oe_b)
    );
endmodule : tmr8_top
`default_nettype wire

// ### verification/tmr8_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tmr8_properties
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus and acks
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic ovf_int_ack,
    input wire logic match_a_int_ack,
    input wire logic match_b_int_ack,
    // flags and pins
    input wire logic overflow_flag,
    input wire logic match_flag_a,
    input wire logic match_flag_b,
    input wire logic port_value_a,
    input wire logic port_value_b,
    input wire logic pin_dir_out_a,
    input wire logic pin_dir_out_b,
    input wire logic pin_out_a,
    input wire logic pin_out_b,
    input wire logic pin_oe_a,
    input wire logic pin_oe_b,
    input wire logic wave_out_a,
    input wire logic wave_out_b
);
    // a flag may only fall after an ack pulse or a write of one
    wire logic fl_wr = avs_write && !avs_waitrequest && avs_address == 4'h4;
    wire logic clr_ovf = ovf_int_ack || (fl_wr && avs_writedata[0]);
    wire logic clr_a = match_a_int_ack || (fl_wr && avs_writedata[1]);
    wire logic clr_b = match_b_int_ack || (fl_wr && avs_writedata[2]);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_oe_dir_a: assert property (pin_oe_a == pin_dir_out_a)
        else $error("pin_oe_a differs from direction");
    a_oe_dir_b: assert property (pin_oe_b == pin_dir_out_b)
        else $error("pin_oe_b differs from direction");
    a_pin_src_a: assert property (pin_out_a != port_value_a |-> pin_out_a == wave_out_a)
        else $error("pin_out_a from neither source");
    a_pin_src_b: assert property (pin_out_b != port_value_b |-> pin_out_b == wave_out_b)
        else $error("pin_out_b from neither source");
    a_ovf_sticky: assert property (overflow_flag && !clr_ovf |=> overflow_flag)
        else $error("overflow flag dropped on its own");
    a_ma_clear_cause: assert property ($fell(match_flag_a) |-> $past(clr_a))
        else $error("match flag a dropped on its own");
    a_mb_clear_cause: assert property ($fell(match_flag_b) |-> $past(clr_b))
        else $error("match flag b dropped on its own");
    a_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("waitrequest not one cycle");
endmodule : tmr8_properties
`default_nettype wire

// ### verification/tmr8_pin_pad.sv
`timescale 1ns/1ps
`default_nettype none
module tmr8_pin_pad
(
    // pin drive from the block
    input wire logic pin_out,
    input wire logic pin_oe,
    // pad level
    output logic pad
);
    // a released pad goes to the pull-up, it never keeps the last level
    assign pad = pin_oe ? pin_out : 1'b1;
endmodule : tmr8_pin_pad
`default_nettype wire

// ### verification/test_timer8_compare_output_ctc.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_cfg.svh"
module test_timer8_compare_output_ctc;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, overflow_flag, match_flag_a, match_flag_b;
    logic ovf_int_ack = 1'b0, match_a_int_ack = 1'b0, match_b_int_ack = 1'b0;
    logic port_value_a = 1'b1, port_value_b = 1'b0, pin_dir_out_a = 1'b0, pin_dir_out_b = 1'b0;
    logic pin_out_a, pin_out_b, pin_oe_a, pin_oe_b, wave_out_a, wave_out_b, pad_a, pad_b, w;
    logic [1:0] act [5] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1};
    logic wexp [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int divs [6] = '{8, 32, 64, 128, 256, 1024};
    int fails = 0;
    int n_tests = 0;
    int n, i;
    always #2 clk = ~clk;
    tmr8_top i_dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .ovf_int_ack, .match_a_int_ack, .match_b_int_ack,
        .overflow_flag, .match_flag_a, .match_flag_b, .port_value_a, .port_value_b,
        .pin_dir_out_a, .pin_dir_out_b, .pin_out_a, .pin_out_b, .pin_oe_a, .pin_oe_b,
        .wave_out_a, .wave_out_b);
    tmr8_pin_pad i_pad_a (.pin_out(pin_out_a), .pin_oe(pin_oe_a), .pad(pad_a));
    tmr8_pin_pad i_pad_b (.pin_out(pin_out_b), .pin_oe(pin_oe_b), .pad(pad_b));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkb
    // one access; returns at the edge where it completed
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    function automatic logic [31:0] cw(input logic [2:0] wgm, cs, input logic [1:0] ca, cb);
        return {20'h0, cb, ca, 1'b0, cs, 1'b0, wgm};
    endfunction : cw
    task automatic tick1;
        @(posedge clk);
        #1;
    endtask : tick1
    // waits for a toggle of wave a, then checks the next toggle comes p cycles later
    task automatic per(input int p);
        w = wave_out_a;
        n = 0;
        while (wave_out_a === w && n < 400)
        begin
            tick1();
            n++;
        end
        w = wave_out_a;
        repeat (p - 1)
        begin
            tick1();
            chkb(wave_out_a, w);
        end
        tick1();
        chkb(wave_out_a, !w);
    endtask : per
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #60000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 7; i++)
        begin
            bus(1'b0, (i == 6) ? 4'hF : 4'(i), 32'h0);
            chk(q, 32'h0);
        end
        bus(1'b1, `TMR8_ADDR_COUNT, 32'h0000_00FD);
        repeat (5) @(posedge clk);
        bus(1'b0, `TMR8_ADDR_COUNT, 32'h0);
        chk(q, 32'h0000_00FD);
        for (i = 0; i < 5; i++)
        begin
            bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h0, 3'h0, act[i], 2'h3));
            bus(1'b1, `TMR8_ADDR_FORCE, 32'h0000_0003);
            tick1();
            chkb(wave_out_a, wexp[i]);
            chkb(pin_out_a, (act[i] != 2'h0) ? wexp[i] : port_value_a);
            chkb(match_flag_a, 1'b0);
        end
        bus(1'b0, `TMR8_ADDR_COUNT, 32'h0);
        chk(q, 32'h0000_00FD);
        chkb(wave_out_b, 1'b1);
        chkb(pad_a, 1'b1);
        pin_dir_out_a <= 1'b1;
        pin_dir_out_b <= 1'b1;
        tick1();
        chkb(pad_a, 1'b0);
        chkb(pad_b, 1'b1);
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h2, 3'h0, 2'h1, 2'h0));
        chkb(wave_out_a, 1'b0);
        chkb(wave_out_b, 1'b1);
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h3, 3'h0, 2'h1, 2'h0));
        bus(1'b1, `TMR8_ADDR_FORCE, 32'h0000_0001);
        tick1();
        chkb(wave_out_a, 1'b0);
        chkb(wave_out_b, 1'b1);
        bus(1'b1, `TMR8_ADDR_CMP_A, 32'h0000_0010);
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h0, 3'h0, 2'h1, 2'h0));
        bus(1'b1, `TMR8_ADDR_COUNT, 32'h0000_0010);
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h0, 3'h1, 2'h1, 2'h0));
        repeat (20) @(posedge clk);
        chkb(match_flag_a, 1'b0);
        chkb(wave_out_a, 1'b0);
        bus(1'b1, `TMR8_ADDR_COUNT, 32'h0000_00FD);
        bus(1'b1, `TMR8_ADDR_COUNT, 32'h0000_0040);
        tick1();
        chkb(overflow_flag, 1'b0);
        bus(1'b1, `TMR8_ADDR_COUNT, 32'h0000_00FE);
        tick1();
        chkb(overflow_flag, 1'b0);
        tick1();
        chkb(overflow_flag, 1'b1);
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h0, 3'h0, 2'h1, 2'h0));
        bus(1'b0, `TMR8_ADDR_COUNT, 32'h0);
        chkb(q > 0 && q < 8, 1'b1);
        chkb(overflow_flag, 1'b1);
        @(posedge clk);
        ovf_int_ack <= 1'b1;
        @(posedge clk);
        ovf_int_ack <= 1'b0;
        #1;
        chkb(overflow_flag, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h0, 3'(i + 2), 2'h0, 2'h0));
            bus(1'b1, `TMR8_ADDR_FLAGS, 32'h0000_0007);
            bus(1'b1, `TMR8_ADDR_COUNT, 32'h0000_00FE);
            n = 0;
            while (overflow_flag !== 1'b1 && n < 2100)
            begin
                @(posedge clk);
                n++;
            end
            chkb(n > divs[i] + 1 && n <= 2 * divs[i] + 1, 1'b1);
        end
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h2, 3'h0, 2'h1, 2'h0));
        bus(1'b1, `TMR8_ADDR_FLAGS, 32'h0000_0007);
        bus(1'b1, `TMR8_ADDR_CMP_A, 32'h0000_0002);
        bus(1'b1, `TMR8_ADDR_CMP_B, 32'h0000_0001);
        bus(1'b1, `TMR8_ADDR_COUNT, 32'h0000_0005);
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h2, 3'h1, 2'h1, 2'h0));
        n = 0;
        while (overflow_flag !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        chkb(match_flag_a, 1'b0);
        per(3);
        chkb(match_flag_a, 1'b1);
        chkb(match_flag_b, 1'b1);
        bus(1'b0, `TMR8_ADDR_COUNT, 32'h0);
        chkb(q <= 2, 1'b1);
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h2, 3'h0, 2'h1, 2'h0));
        @(posedge clk);
        match_b_int_ack <= 1'b1;
        @(posedge clk);
        match_b_int_ack <= 1'b0;
        #1;
        chkb(match_flag_b, 1'b0);
        bus(1'b1, `TMR8_ADDR_FLAGS, 32'h0000_0002);
        tick1();
        chkb(match_flag_a, 1'b0);
        bus(1'b1, `TMR8_ADDR_CMP_A, 32'h0);
        bus(1'b1, `TMR8_ADDR_COUNT, 32'h0000_00FF);
        bus(1'b1, `TMR8_ADDR_CTRL, cw(3'h2, 3'h1, 2'h1, 2'h0));
        per(1);
        per(1);
        tally_and_finish();
    end
endmodule : test_timer8_compare_output_ctc
bind tmr8_top tmr8_properties i_props (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_waitrequest, .ovf_int_ack, .match_a_int_ack, .match_b_int_ack,
    .overflow_flag, .match_flag_a, .match_flag_b, .port_value_a, .port_value_b,
    .pin_dir_out_a, .pin_dir_out_b, .pin_out_a, .pin_out_b, .pin_oe_a, .pin_oe_b,
    .wave_out_a, .wave_out_b);
`default_nettype wire
